// [hdl/spi_sec_params.svh]
// Purpose: Constants for the serial flash security command block.
// Assumes: System clock of 40 MHz sampling the SPI pins.
// Notes: Operation summary follows.
// Operation
// - Opcode 35h, address, then output every clock.
// - Lockdown query repeats 00h or FFh.
// - Chip select release ends reads, output floats.
// - 128 bytes: 64 user, 64 fixed factory.
// - Write enabled, opcode 9Bh, address, buffered data.
// - Program uses only low six address bits.
// - Unaligned program data wraps past location 63.
// - Only last 64 data bytes are kept.
// - Release programs received bytes, others stay FFh.
// - Programming self-timed and never suspended.
// - User area programmable once, retries abort.
// - Bad address, data or boundary aborts, clears latch.
// - Busy while programming, latch cleared before end.
// - Program uses shared 256-byte page buffer.
// - No erase needed, blank locations read FFh.
// - Opcode 77h, address, two dummies, sequential output.
// - Read wraps from 7Fh to 00h seamlessly.
// - Status bit 0 busy, bit 1 latch.
`ifndef SPI_SEC_PARAMS_SVH
`define SPI_SEC_PARAMS_SVH

`define OP_LOCK_READ 8'h35
`define OP_OTP_PROG 8'h9B
`define OP_OTP_READ 8'h77
`define LOCK_BYTE_SET 8'hFF
`define LOCK_BYTE_CLR 8'h00
`define OTP_ERASED 8'hFF
`define OTP_BYTES 128
`define OTP_USER_BYTES 64
`define OTP_USER_LAST 6'h3F
`define OTP_LAST_ADDR 7'h7F
`define PAGE_BUF_BYTES 256
`define ADDR_LAST_IDX 2'h2
`define DUMMY_LAST_IDX 2'h1
`define SECTOR_MSB 20
`define SECTOR_LSB 16
`define STAT_BUSY_BIT 0
`define STAT_WEL_BIT 1
// Arbitrary value used to fill the factory half of the security area.
`define FACTORY_SEED 8'h5A
`define FIFO_WIDTH 8
`define FIFO_DEPTH 8
`define SYS_CLK_MHZ 40
`define OTP_PROGRAM_TIME_US 1000
// Longest time, so the product is taken whole and never rounded up.
`define OTP_PROG_CYCLES (`OTP_PROGRAM_TIME_US * `SYS_CLK_MHZ)

`endif

// [hdl/spi_sec_pkg.sv]
// Purpose: Types for the serial flash security command block.
// Assumes: Nothing beyond the parameter header.
// Notes: States are binary coded.
package spi_sec_pkg;
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_LOCK_OUT = 3'b011,
    ST_OTP_OUT = 3'b100,
    ST_PROG_DATA = 3'b101,
    ST_IGNORE = 3'b110
  } spi_state_t;
endpackage : spi_sec_pkg

// [hdl/sec_fifo.sv]
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock domain, DEPTH a power of two.
// Notes: Full and empty come from pointers with one extra wrap bit.
`timescale 1ns/10ps
module sec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  logic full;
  logic empty;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign push = in_valid_i & ~full;
  assign pop = out_ready_i & ~empty;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end
endmodule : sec_fifo

// [hdl/spi_flash_security_cmds.sv]
// Purpose: Lockdown query, security area program and security area read.
// Assumes: SPI mode 0 or 3, pins sampled by sys_clk_i at least 8x the SPI rate.
// Notes: Latch and lockdown bits come from the rest of the device.
`timescale 1ns/10ps
`include "spi_sec_params.svh"
module spi_flash_security_cmds #(
  parameter int unsigned OTP_PROG_CYCLES = `OTP_PROG_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic spi_cs_b_i,
  input wire logic spi_sck_i,
  input wire logic spi_si_i,
  output logic spi_so_o,
  output logic spi_so_oe_b_o,
  input wire logic [31:0] lockdown_bits_i,
  input wire logic write_enable_latch_i,
  output logic wel_clear_o,
  output logic device_busy_flag_o,
  output logic [7:0] status_byte1_o,
  output logic otp_programmed_o
);

  function automatic logic is_out_state(input spi_sec_pkg::spi_state_t s);
    is_out_state = (s == spi_sec_pkg::ST_LOCK_OUT) || (s == spi_sec_pkg::ST_OTP_OUT);
  endfunction : is_out_state

  // Factory contents are arbitrary; they only need to be fixed per device.
  function automatic logic [7:0] factory_byte(input int idx);
    factory_byte = `FACTORY_SEED ^ idx[7:0];
  endfunction : factory_byte

  logic cs_m, cs_s, cs_d, sck_m, sck_s, sck_d, si_m, si_s;
  spi_sec_pkg::spi_state_t state, next_state;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [6:0] shift_in;
  logic [15:0] addr_hi;
  logic [7:0] cmd;
  logic prog_armed;
  logic got_byte;
  logic [4:0] lock_sector;
  logic [6:0] otp_rd_addr;
  logic [7:0] otp_rdata;
  logic [5:0] wr_loc;
  logic [63:0] loc_mask;
  logic [7:0] page_buf [0:`PAGE_BUF_BYTES-1];
  logic [7:0] otp_mem [0:`OTP_BYTES-1];
  logic pend_valid;
  logic [7:0] pend_byte;
  logic [31:0] prog_timer;

  logic sck_rise, sck_fall, cs_rel, byte_done, addr_last, prog_accept;
  logic [7:0] rx_byte;
  logic [23:0] full_addr;
  logic rel_ok, start_prog, abort_prog, copy_now;
  logic fifo_in_ready, fifo_out_valid, drain_ready, drain;
  logic [7:0] fifo_out_data;
  logic lock_hit;
  logic [7:0] tx_byte;

  // Pins are asynchronous to sys_clk_i; edges are found on the second stage only.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {cs_m, cs_s, cs_d} <= 3'h7;
      {sck_m, sck_s, sck_d} <= 3'h0;
      {si_m, si_s} <= 2'h0;
    end else begin
      {cs_m, cs_s, cs_d} <= {spi_cs_b_i, cs_m, cs_s};
      {sck_m, sck_s, sck_d} <= {spi_sck_i, sck_m, sck_s};
      {si_m, si_s} <= {spi_si_i, si_m};
    end
  end

  assign sck_rise = sck_s & ~sck_d & ~cs_s;
  assign sck_fall = ~sck_s & sck_d & ~cs_s;
  assign cs_rel = cs_s & ~cs_d;
  assign rx_byte = {shift_in, si_s};
  assign byte_done = sck_rise & (bit_cnt == 3'h7);
  assign full_addr = {addr_hi, rx_byte};
  assign addr_last = byte_done && (state == spi_sec_pkg::ST_ADDR) && (byte_cnt == `ADDR_LAST_IDX);
  // A program opcode without the latch, or while busy, is ignored whole.
  assign prog_accept = (rx_byte == `OP_OTP_PROG) & write_enable_latch_i & ~device_busy_flag_o;

  always_comb begin
    next_state = state;
    if (byte_done) begin
      case (state)
        spi_sec_pkg::ST_CMD: begin
          if (rx_byte == `OP_LOCK_READ || rx_byte == `OP_OTP_READ || prog_accept) begin
            next_state = spi_sec_pkg::ST_ADDR;
          end else begin
            next_state = spi_sec_pkg::ST_IGNORE;
          end
        end
        spi_sec_pkg::ST_ADDR: begin
          if (byte_cnt == `ADDR_LAST_IDX) begin
            if (cmd == `OP_LOCK_READ) begin
              next_state = spi_sec_pkg::ST_LOCK_OUT;
            end else if (cmd == `OP_OTP_READ) begin
              next_state = spi_sec_pkg::ST_DUMMY;
            end else begin
              next_state = spi_sec_pkg::ST_PROG_DATA;
            end
          end
        end
        spi_sec_pkg::ST_DUMMY: begin
          if (byte_cnt == `DUMMY_LAST_IDX) begin
            next_state = spi_sec_pkg::ST_OTP_OUT;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  // Deselect returns to opcode phase at any bit position.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= spi_sec_pkg::ST_CMD;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
      shift_in <= 7'h00;
    end else if (cs_s) begin
      state <= spi_sec_pkg::ST_CMD;
      bit_cnt <= 3'h0;
      byte_cnt <= 2'h0;
    end else if (sck_rise) begin
      state <= next_state;
      bit_cnt <= bit_cnt + 3'h1;
      shift_in <= rx_byte[6:0];
      if (byte_done) begin
        byte_cnt <= (next_state != state) ? 2'h0 : byte_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd <= 8'h00;
      prog_armed <= 1'b0;
      got_byte <= 1'b0;
      addr_hi <= 16'h0000;
    end else if (cs_s) begin
      prog_armed <= 1'b0;
      got_byte <= 1'b0;
    end else if (byte_done) begin
      addr_hi <= {addr_hi[7:0], rx_byte};
      if (state == spi_sec_pkg::ST_CMD) begin
        cmd <= rx_byte;
        prog_armed <= prog_accept;
      end
      if (state == spi_sec_pkg::ST_PROG_DATA) begin
        got_byte <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_sector <= 5'h00;
      otp_rd_addr <= 7'h00;
    end else if (addr_last) begin
      lock_sector <= full_addr[`SECTOR_MSB:`SECTOR_LSB];
      otp_rd_addr <= full_addr[6:0];
    end else if (byte_done && state == spi_sec_pkg::ST_OTP_OUT) begin
      otp_rd_addr <= otp_rd_addr + 7'h01;
    end
  end

  // Data bytes wait here until the FIFO takes them.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_valid <= 1'b0;
      pend_byte <= 8'h00;
    end else if (byte_done && state == spi_sec_pkg::ST_PROG_DATA) begin
      pend_valid <= 1'b1;
      pend_byte <= rx_byte;
    end else if (fifo_in_ready) begin
      pend_valid <= 1'b0;
    end
  end

  sec_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(pend_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pend_byte),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(drain_ready),
    .out_data_o(fifo_out_data)
  );

  // The drain stalls in the copy cycle so the buffer is not read and written together.
  assign drain_ready = ~copy_now;
  assign drain = fifo_out_valid & drain_ready;

  // Writing at the target location means a later lap overwrites an earlier one.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_loc <= 6'h00;
      loc_mask <= 64'h0;
    end else begin
      if (byte_done && state == spi_sec_pkg::ST_CMD && prog_accept) begin
        loc_mask <= 64'h0;
      end else if (drain) begin
        loc_mask[wr_loc] <= 1'b1;
      end
      if (addr_last) begin
        wr_loc <= full_addr[5:0];
      end else if (drain) begin
        wr_loc <= wr_loc + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (drain) begin
      page_buf[{2'h0, wr_loc}] <= fifo_out_data;
    end
  end

  assign rel_ok = (state == spi_sec_pkg::ST_PROG_DATA) && (bit_cnt == 3'h0) && got_byte;
  assign start_prog = cs_rel & prog_armed & rel_ok & ~otp_programmed_o;
  assign abort_prog = cs_rel & prog_armed & ~start_prog;
  assign copy_now = device_busy_flag_o && (prog_timer == 32'h0);

  // No suspend input reaches this engine, so a started cycle always completes.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      device_busy_flag_o <= 1'b0;
      prog_timer <= 32'h0;
      otp_programmed_o <= 1'b0;
      wel_clear_o <= 1'b0;
    end else begin
      wel_clear_o <= start_prog | abort_prog;
      if (start_prog) begin
        device_busy_flag_o <= 1'b1;
        prog_timer <= OTP_PROG_CYCLES - 32'h1;
        otp_programmed_o <= 1'b1;
      end else if (device_busy_flag_o) begin
        if (prog_timer == 32'h0) begin
          device_busy_flag_o <= 1'b0;
        end else begin
          prog_timer <= prog_timer - 32'h1;
        end
      end
    end
  end

  // Reset models the shipped state: blank user half, fixed factory half.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < `OTP_BYTES; i++) begin
        otp_mem[i] <= (i < `OTP_USER_BYTES) ? `OTP_ERASED : factory_byte(i);
      end
    end else if (copy_now) begin
      for (int i = 0; i < `OTP_USER_BYTES; i++) begin
        if (loc_mask[i]) begin
          otp_mem[i] <= page_buf[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      otp_rdata <= 8'h00;
    end else begin
      otp_rdata <= otp_mem[otp_rd_addr];
    end
  end

  assign lock_hit = lockdown_bits_i[lock_sector];
  assign tx_byte = (state == spi_sec_pkg::ST_LOCK_OUT) ?
                   (lock_hit ? `LOCK_BYTE_SET : `LOCK_BYTE_CLR) : otp_rdata;

  // Output bits change on the falling clock so they are stable for the host's rise.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spi_so_o <= 1'b0;
      spi_so_oe_b_o <= 1'b1;
    end else begin
      spi_so_oe_b_o <= cs_s | ~is_out_state(state);
      if (sck_fall && is_out_state(state)) begin
        spi_so_o <= tx_byte[~bit_cnt];
      end
    end
  end

  always_comb begin
    status_byte1_o = 8'h00;
    status_byte1_o[`STAT_BUSY_BIT] = device_busy_flag_o;
    status_byte1_o[`STAT_WEL_BIT] = write_enable_latch_i;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_prog_release;
    cs_rel && prog_armed;
  endsequence

  sequence s_busy_hold;
    device_busy_flag_o [*8];
  endsequence

  lock_opcode_a: assert property (byte_done && state == spi_sec_pkg::ST_CMD &&
    rx_byte == `OP_LOCK_READ |=> state == spi_sec_pkg::ST_ADDR)
    else $error("Lockdown opcode not taken.");
  lock_value_a: assert property (sck_fall && state == spi_sec_pkg::ST_LOCK_OUT
    |=> spi_so_o == $past(lock_hit))
    else $error("Lockdown output bit wrong.");
  so_release_a: assert property (cs_rel |=> spi_so_oe_b_o ##1 spi_so_oe_b_o)
    else $error("Output still driven after deselect.");
  factory_fixed_a: assert property (otp_mem[`OTP_BYTES-1] == factory_byte(`OTP_BYTES-1))
    else $error("Factory byte changed.");
  prog_addr_a: assert property (addr_last && cmd == `OP_OTP_PROG
    |=> wr_loc == $past(rx_byte[5:0]))
    else $error("Program start location wrong.");
  user_wrap_a: assert property (drain && wr_loc == `OTP_USER_LAST |=> wr_loc == 6'h00)
    else $error("User area did not wrap.");
  abort_clean_a: assert property (s_prog_release ##0 (!rel_ok || otp_programmed_o)
    |=> wel_clear_o && !$rose(device_busy_flag_o))
    else $error("Aborted program misbehaved.");
  busy_hold_a: assert property (start_prog |=> wel_clear_o ##0 s_busy_hold)
    else $error("Busy or latch clear missing at program start.");
  one_time_a: assert property ($rose(device_busy_flag_o) |-> !$past(otp_programmed_o))
    else $error("User area programmed twice.");
  read_wrap_a: assert property (byte_done && state == spi_sec_pkg::ST_OTP_OUT &&
    otp_rd_addr == `OTP_LAST_ADDR |=> otp_rd_addr == 7'h00)
    else $error("Read did not wrap to zero.");
endmodule : spi_flash_security_cmds

// [tb/spi_host_model.sv]
// Purpose: SPI host model driving chip select, serial clock and serial input.
// Assumes: Mode 0, clock four system clocks low and four high (200 ns).
// Notes: Every task begins and ends on a rising system clock edge.
`timescale 1ns/10ps
module spi_host_model (
  input wire logic sys_clk_i,
  output logic cs_b_o,
  output logic sck_o,
  output logic si_o,
  input wire logic so_i
);
  initial begin
    cs_b_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b1;
  end

  task automatic start;
    @(posedge sys_clk_i);
    cs_b_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask : start

  // Output is sampled late in the high phase, clear of the change after the next fall.
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck_o <= 1'b0;
      si_o <= tx[i];
      repeat (4) @(posedge sys_clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rx[i] = so_i;
    end
  endtask : bits

  task automatic stop;
    sck_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    cs_b_o <= 1'b1;
    // A released input shows the inverse of its last value, never a stale level.
    si_o <= ~si_o;
    repeat (8) @(posedge sys_clk_i);
  endtask : stop
endmodule : spi_host_model

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the security command block.
// Assumes: Short program time of 16 cycles; latch modelled here.
// Notes: A second reset gives a fresh user area for the overflow case.
`timescale 1ns/10ps
`include "spi_sec_params.svh"
`define CHECK_EQ(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic write_enable_latch = 1'b0;
  logic [31:0] lock_bits = 32'h0000_0004;
  logic cs_b, sck, si, so, so_oe_b, wel_clr, busy, prog_done;
  logic [7:0] status;
  logic [7:0] rx;
  logic [7:0] exp_rd [8];
  int fail_count = 0;
  int checks_done = 0;
  int busy_len = 0;
  int busy_stat = 0;
  int clr_cnt = 0;

  always #12.5 sys_clk = ~sys_clk;

  // The latch lives outside the block, so the bench plays its clear input.
  always @(posedge sys_clk) begin
    if (wel_clr === 1'b1) write_enable_latch <= 1'b0;
  end

  always @(posedge sys_clk) begin
    if (rst_b === 1'b0) begin
      busy_len <= 0;
      busy_stat <= 0;
      clr_cnt <= 0;
    end else begin
      if (busy === 1'b1) busy_len <= busy_len + 1;
      if (status[0] === 1'b1) busy_stat <= busy_stat + 1;
      if (wel_clr === 1'b1) clr_cnt <= clr_cnt + 1;
    end
  end

  spi_host_model i_spi_host_model (
    .sys_clk_i(sys_clk),
    .cs_b_o(cs_b),
    .sck_o(sck),
    .si_o(si),
    .so_i(so)
  );

  spi_flash_security_cmds #(.OTP_PROG_CYCLES(16)) i_spi_flash_security_cmds (
    .sys_clk_i(sys_clk),
    .rst_b_i(rst_b),
    .spi_cs_b_i(cs_b),
    .spi_sck_i(sck),
    .spi_si_i(si),
    .spi_so_o(so),
    .spi_so_oe_b_o(so_oe_b),
    .lockdown_bits_i(lock_bits),
    .write_enable_latch_i(write_enable_latch),
    .wel_clear_o(wel_clr),
    .device_busy_flag_o(busy),
    .status_byte1_o(status),
    .otp_programmed_o(prog_done)
  );

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : do_reset

  task automatic put(input logic [7:0] b);
    i_spi_host_model.bits(b, 8, rx);
  endtask : put

  task automatic cmd(input logic [7:0] op, input logic [23:0] addr);
    i_spi_host_model.start();
    put(op);
    for (int i = 2; i >= 0; i--) begin
      put(addr[8*i +: 8]);
    end
  endtask : cmd

  task automatic rd_otp(input logic [23:0] addr);
    cmd(`OP_OTP_READ, addr);
    put(8'h00);
    put(8'h00);
  endtask : rd_otp

  task automatic wait_prog;
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge sys_clk);
      if (busy_len > 0 && busy === 1'b0) break;
    end
    if (i == 100) begin
      fail_count++;
      close_out();
    end
  endtask : wait_prog

  initial begin
    exp_rd = '{8'hFF, 8'hA1, 8'hA2, `FACTORY_SEED ^ 8'h40,
      `FACTORY_SEED ^ 8'h7F, 8'hA3, 8'hFF, 8'h00};
    do_reset();
    `CHECK_EQ(status, 8'h00)
    `CHECK_EQ(so_oe_b, 1'b1)
    write_enable_latch <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHECK_EQ(status, 8'h02)
    for (int s = 2; s <= 3; s++) begin
      cmd(`OP_LOCK_READ, {3'h0, 5'(s), 16'hA5C3});
      put(8'h00);
      `CHECK_EQ(so_oe_b, 1'b0)
      put(8'h00);
      `CHECK_EQ(rx, (s == 2) ? `LOCK_BYTE_SET : `LOCK_BYTE_CLR)
      i_spi_host_model.bits(8'h00, 3, rx);
      i_spi_host_model.stop();
      `CHECK_EQ(so_oe_b, 1'b1)
    end
    rd_otp(24'h00007E);
    for (int k = 0; k < 3; k++) begin
      put(8'h00);
      `CHECK_EQ(rx, k < 2 ? `FACTORY_SEED ^ 8'(8'h7E + k) : `OTP_ERASED)
    end
    i_spi_host_model.stop();
    // Without the latch the command is ignored and the latch is left alone.
    write_enable_latch <= 1'b0;
    cmd(`OP_OTP_PROG, 24'h0);
    put(8'h11);
    i_spi_host_model.stop();
    `CHECK_EQ(clr_cnt + busy_len, 0)
    for (int a = 0; a < 2; a++) begin
      write_enable_latch <= 1'b1;
      cmd(`OP_OTP_PROG, 24'h0);
      if (a == 1) begin
        put(8'h22);
        i_spi_host_model.bits(8'h00, 3, rx);
      end
      i_spi_host_model.stop();
      `CHECK_EQ(clr_cnt, a + 1)
      `CHECK_EQ(busy_len, 0)
    end
    write_enable_latch <= 1'b1;
    cmd(`OP_OTP_PROG, 24'hFFFFFE);
    put(8'hA1);
    put(8'hA2);
    put(8'hA3);
    i_spi_host_model.stop();
    wait_prog();
    `CHECK_EQ(busy_len, 16)
    `CHECK_EQ(busy_stat, 16)
    `CHECK_EQ(clr_cnt, 3)
    `CHECK_EQ(prog_done, 1'b1)
    for (int r = 0; r < 2; r++) begin
      rd_otp(r == 0 ? 24'h00003D : 24'h00007F);
      for (int k = 0; k < 4 - r; k++) begin
        put(8'h00);
        `CHECK_EQ(rx, exp_rd[r*4 + k])
      end
      i_spi_host_model.stop();
    end
    write_enable_latch <= 1'b1;
    cmd(`OP_OTP_PROG, 24'h0);
    put(8'h00);
    i_spi_host_model.stop();
    `CHECK_EQ(clr_cnt, 4)
    `CHECK_EQ(busy_len, 16)
    do_reset();
    write_enable_latch <= 1'b1;
    cmd(`OP_OTP_PROG, 24'h00003E);
    for (int n = 0; n < 66; n++) begin
      put(8'(n));
    end
    i_spi_host_model.stop();
    wait_prog();
    rd_otp(24'h0);
    for (int k = 0; k < 64; k++) begin
      put(8'h00);
      `CHECK_EQ(rx, ((k + 2) % 64 < 2) ? 8'((k + 2) % 64 + 64) : 8'((k + 2) % 64))
    end
    i_spi_host_model.stop();
    close_out();
  end
endmodule : tb_top
